// ### dcmc_pkg.sv
package dcmc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OSC_MODE_CTRL_IDX = 8'hca;
  localparam logic [9:0] ADDR_OSC_MODE     = 10'h328;
  localparam logic [9:0] ADDR_IRQ_STATUS   = 10'h330;
  localparam logic [9:0] ADDR_IRQ_MASK     = 10'h334;
  localparam logic [9:0] ADDR_CLK_STATUS   = 10'h338;
  localparam logic [9:0] ADDR_TIMER_EN     = 10'h33c;

  // ---------------------------------------------------------------
  // oscillator_mode_control fields
  // ---------------------------------------------------------------
  localparam int BIT_HIGH_OSC_STOP   = 1;
  localparam int BIT_SLOW_CLOCK_SEL  = 2;
  localparam int BIT_CPU_MODE_LO     = 3;
  localparam int BIT_CPU_MODE_HI     = 4;
  localparam logic [7:0] OSC_MODE_WMASK = 8'h1e;
  localparam logic [7:0] OSC_MODE_RST   = 8'h00;

  // ---------------------------------------------------------------
  // status / irq bit positions
  // ---------------------------------------------------------------
  localparam int IRQ_WAKE      = 0;
  localparam int IRQ_MODE_CHG  = 1;
  localparam int IRQ_OSC_READY = 2;
  localparam int IRQ_W         = 3;

  localparam int TMR_EN_T0  = 0;
  localparam int TMR_EN_TC0 = 1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SLOW_DIV        = 4;
  localparam int NOISE_MIN_DIV   = 4;
  localparam int MAX_DIV         = 128;
  localparam int WAKE_HOSC_CLKS  = 2048;

  typedef enum logic [1:0] {
    DCMC_CPUM_NORMAL = 2'b00,
    DCMC_CPUM_SLEEP  = 2'b01,
    DCMC_CPUM_GREEN  = 2'b10,
    DCMC_CPUM_RSVD   = 2'b11
  } dcmc_cpum_t;

  typedef enum logic [1:0] {
    DCMC_HCLK_RC,
    DCMC_HCLK_32K,
    DCMC_HCLK_12M,
    DCMC_HCLK_4M
  } dcmc_hclk_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dcmc_wb_req_t;

  typedef struct packed {
    logic       high_osc_run;
    logic       low_rc_run;
    logic       cpu_run;
    logic       sys_on_low;
  } dcmc_gate_t;

endpackage

// ### dcmc_clk_sel.sv
`timescale 1ns/1ps
// glitch-free selection between high and low clock enables
module dcmc_clk_sel
  import dcmc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic sel_low_in,
  input  wire logic hi_tick_in,
  input  wire logic lo_tick_in,
  output logic      on_low_out,
  output logic      tick_out
);

  logic on_low_r;
  logic on_low_nxt;

  // only switch on a tick of the source being left, so no runt period is emitted
  always_comb begin
    on_low_nxt = on_low_r;
    if (sel_low_in != on_low_r) begin
      if (on_low_r ? lo_tick_in : hi_tick_in) begin
        on_low_nxt = sel_low_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      on_low_r <= 1'b0;
    end else begin
      on_low_r <= on_low_nxt;
    end
  end

  assign on_low_out = on_low_r;
  assign tick_out   = on_low_r ? lo_tick_in : hi_tick_in;

endmodule // dcmc_clk_sel

// ### dcmc_ctrl.sv
`timescale 1ns/1ps

// Overview of operation
// - slow mode cpu rate is low rc over four
// - normal mode rate is high clock over N
// - noise filter forces divider at least four
// - stop bit halts high oscillator only, once the system clock is on the low clock
// - clock select bit picks high or low clock
// - cpu mode field encodes normal, sleep, green
// - sleep stops both oscillators
// - low rc stops in sleep or green-32k-nowatchdog
// - no software bit stops low rc directly
// - low rc clocks watchdog and slow mode
// - high clock type option; rc frees pin two
// - cpu, low rc, high osc run per mode
// - timers count when enabled, never in sleep or in the wakeup warmup
// - green wakeup returns to previous mode
// - sleep wakeup waits 2048 high clocks first
module dcmc_ctrl
  import dcmc_pkg::*;
#(
  parameter int         CPU_DIV_N      = 4,
  parameter bit         NOISE_FILTER   = 1'b1,
  parameter dcmc_hclk_t HIGH_CLK_TYPE  = DCMC_HCLK_4M,
  parameter bit         WATCHDOG_EN    = 1'b1
)(
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [9:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic [31:0]      WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic        HOSC_CLK_IN,
  input  wire logic        LRC_CLK_IN,
  input  wire logic        WAKE_PORT_IN,
  input  wire logic        TIMER0_OVF_IN,
  output logic             HIGH_OSC_EN_OUT,
  output logic             LOW_RC_EN_OUT,
  output logic             CPU_RUN_OUT,
  output logic             CPU_TICK_OUT,
  output logic             WDT_TICK_OUT,
  output logic             TIMER0_RUN_OUT,
  output logic             TIMER_COUNTER0_RUN_OUT,
  output logic             OSC_OUTPUT_PIN_GPIO_OUT,
  output logic             IRQ_OUT
);

  // ---------------------------------------------------------------
  // divider limits
  // ---------------------------------------------------------------
  localparam int DIV_RAW = (CPU_DIV_N < 1) ? 1 : ((CPU_DIV_N > MAX_DIV) ? MAX_DIV : CPU_DIV_N);
  localparam int DIV_EFF = (NOISE_FILTER && DIV_RAW < NOISE_MIN_DIV) ? NOISE_MIN_DIV : DIV_RAW;
  localparam logic [7:0] HI_DIV_LAST = 8'(DIV_EFF - 1);
  localparam logic [1:0] LO_DIV_LAST = 2'(SLOW_DIV - 1);
  localparam logic [11:0] WAKE_LAST  = 12'(WAKE_HOSC_CLKS - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] hosc_sync_r;
  logic [1:0] lrc_sync_r;
  logic [1:0] wake_sync_r;
  logic [1:0] t0ovf_sync_r;
  logic       hosc_prev_r;
  logic       lrc_prev_r;
  logic       wake_prev_r;
  logic       t0ovf_prev_r;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      hosc_sync_r  <= 2'h0;
      lrc_sync_r   <= 2'h0;
      wake_sync_r  <= 2'h0;
      t0ovf_sync_r <= 2'h0;
      hosc_prev_r  <= 1'b0;
      lrc_prev_r   <= 1'b0;
      wake_prev_r  <= 1'b0;
      t0ovf_prev_r <= 1'b0;
    end else begin
      hosc_sync_r  <= {hosc_sync_r[0], HOSC_CLK_IN};
      lrc_sync_r   <= {lrc_sync_r[0], LRC_CLK_IN};
      wake_sync_r  <= {wake_sync_r[0], WAKE_PORT_IN};
      t0ovf_sync_r <= {t0ovf_sync_r[0], TIMER0_OVF_IN};
      hosc_prev_r  <= hosc_sync_r[1];
      lrc_prev_r   <= lrc_sync_r[1];
      wake_prev_r  <= wake_sync_r[1];
      t0ovf_prev_r <= t0ovf_sync_r[1];
    end
  end

  logic hosc_edge;
  logic lrc_edge;
  logic wake_evt;
  logic t0ovf_evt;
  assign hosc_edge = hosc_sync_r[1] & ~hosc_prev_r;
  assign lrc_edge  = lrc_sync_r[1] & ~lrc_prev_r;
  assign wake_evt  = wake_sync_r[1] ^ wake_prev_r;   // any level change
  assign t0ovf_evt = t0ovf_sync_r[1] & ~t0ovf_prev_r;

  // ---------------------------------------------------------------
  // registers and mode state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DCMC_ST_RUN, DCMC_ST_GREEN, DCMC_ST_SLEEP, DCMC_ST_WARM} dcmc_state_t;

  dcmc_state_t       state_r, state_nxt;
  logic [7:0]        osc_mode_r, osc_mode_nxt;
  logic [IRQ_W-1:0]  irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0]  irq_mask_r, irq_mask_nxt;
  logic [1:0]        tmr_en_r, tmr_en_nxt;
  logic [11:0]       warm_cnt_r, warm_cnt_nxt;
  logic [7:0]        hi_div_r, hi_div_nxt;
  logic [1:0]        lo_div_r, lo_div_nxt;
  logic              ack_r, ack_nxt;
  logic [31:0]       rdat_r, rdat_nxt;
  dcmc_gate_t        gate;

  function automatic logic [31:0] wb_wmask(input logic [3:0] sel);
    wb_wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic        wb_req;
  logic [31:0] wmask;
  logic [31:0] wdat;
  logic        lrc_allowed;
  logic        hi_tick;
  logic        lo_tick;
  logic        sys_tick;
  logic        on_low;
  dcmc_cpum_t  cpum_req;

  assign wb_req   = WB_CYC_IN & WB_STB_IN & ~ack_r;
  assign wmask    = wb_wmask(WB_SEL_IN);
  assign wdat     = WB_DAT_IN & wmask;
  assign cpum_req = dcmc_cpum_t'(osc_mode_r[BIT_CPU_MODE_HI:BIT_CPU_MODE_LO]);

  // low rc stops only in sleep, or green with 32k high clock and no watchdog
  assign lrc_allowed = state_r != DCMC_ST_SLEEP &&
                       !(state_r == DCMC_ST_GREEN && HIGH_CLK_TYPE == DCMC_HCLK_32K && !WATCHDOG_EN);

  // ---------------------------------------------------------------
  // oscillator gating per mode
  // ---------------------------------------------------------------
  always_comb begin
    // stop bit waits until the system clock has left the high source, else the cpu starves
    gate.high_osc_run = (state_r == DCMC_ST_WARM) ||
                        ((~osc_mode_r[BIT_HIGH_OSC_STOP] || ~on_low) && state_r != DCMC_ST_SLEEP);
    gate.low_rc_run = lrc_allowed;
    gate.cpu_run    = state_r == DCMC_ST_RUN;
    gate.sys_on_low = osc_mode_r[BIT_SLOW_CLOCK_SEL];
  end

  // ---------------------------------------------------------------
  // rate dividers
  // ---------------------------------------------------------------
  always_comb begin
    hi_div_nxt = hi_div_r;
    lo_div_nxt = lo_div_r;
    hi_tick    = 1'b0;
    lo_tick    = 1'b0;
    if (hosc_edge && gate.high_osc_run) begin
      hi_tick    = hi_div_r == HI_DIV_LAST;
      hi_div_nxt = hi_tick ? 8'h00 : hi_div_r + 8'h01;
    end
    if (lrc_edge && gate.low_rc_run) begin
      lo_tick    = lo_div_r == LO_DIV_LAST;
      lo_div_nxt = lo_div_r + 2'h1;
    end
    if (gate.sys_on_low != on_low && (on_low ? lo_tick : hi_tick)) begin
      hi_div_nxt = on_low ? 8'h00 : hi_div_nxt;
      lo_div_nxt = on_low ? lo_div_nxt : 2'h0;
    end
  end

  dcmc_clk_sel u_clk_sel (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .sel_low_in (gate.sys_on_low),
    .hi_tick_in (hi_tick),
    .lo_tick_in (lo_tick),
    .on_low_out (on_low),
    .tick_out   (sys_tick)
  );

  // ---------------------------------------------------------------
  // mode sequencer and register file
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    osc_mode_nxt = osc_mode_r;
    irq_mask_nxt = irq_mask_r;
    tmr_en_nxt   = tmr_en_r;
    warm_cnt_nxt = warm_cnt_r;
    ack_nxt      = wb_req;
    rdat_nxt     = 32'h0000_0000;
    irq_stat_nxt = irq_stat_r;

    if (wb_req && WB_WE_IN) begin
      unique case (WB_ADR_IN)
        ADDR_OSC_MODE: begin
          osc_mode_nxt = (osc_mode_r & ~(OSC_MODE_WMASK & wmask[7:0])) |
                         (wdat[7:0] & OSC_MODE_WMASK);
        end
        ADDR_IRQ_STATUS: irq_stat_nxt = irq_stat_r & ~wdat[IRQ_W-1:0];
        ADDR_IRQ_MASK:   irq_mask_nxt = (irq_mask_r & ~wmask[IRQ_W-1:0]) | wdat[IRQ_W-1:0];
        ADDR_TIMER_EN:   tmr_en_nxt   = (tmr_en_r & ~wmask[1:0]) | wdat[1:0];
        default: ;
      endcase
    end else if (wb_req) begin
      unique case (WB_ADR_IN)
        ADDR_OSC_MODE:   rdat_nxt = {24'h000000, osc_mode_r};
        ADDR_IRQ_STATUS: rdat_nxt = {29'h0, irq_stat_r};
        ADDR_IRQ_MASK:   rdat_nxt = {29'h0, irq_mask_r};
        ADDR_CLK_STATUS: rdat_nxt = {26'h0, state_r, gate.cpu_run, on_low,
                                     gate.low_rc_run, gate.high_osc_run};
        ADDR_TIMER_EN:   rdat_nxt = {30'h0, tmr_en_r};
        default:         rdat_nxt = 32'h0000_0000;
      endcase
    end

    unique case (state_r)
      DCMC_ST_RUN: begin
        if (cpum_req == DCMC_CPUM_SLEEP) begin
          state_nxt = DCMC_ST_SLEEP;
          irq_stat_nxt[IRQ_MODE_CHG] = 1'b1;
        end else if (cpum_req == DCMC_CPUM_GREEN) begin
          state_nxt = DCMC_ST_GREEN;
          irq_stat_nxt[IRQ_MODE_CHG] = 1'b1;
        end
        // reserved code leaves the mode alone
      end
      DCMC_ST_GREEN: begin
        if (wake_evt || (t0ovf_evt && tmr_en_r[TMR_EN_T0])) begin
          state_nxt = DCMC_ST_RUN;
          osc_mode_nxt[BIT_CPU_MODE_HI:BIT_CPU_MODE_LO] = DCMC_CPUM_NORMAL;
          irq_stat_nxt[IRQ_WAKE] = 1'b1;
        end
      end
      DCMC_ST_SLEEP: begin
        if (wake_evt) begin
          state_nxt    = DCMC_ST_WARM;
          warm_cnt_nxt = 12'h000;
          osc_mode_nxt[BIT_HIGH_OSC_STOP]  = 1'b0;
          osc_mode_nxt[BIT_SLOW_CLOCK_SEL] = 1'b0;
          irq_stat_nxt[IRQ_WAKE] = 1'b1;
        end
      end
      DCMC_ST_WARM: begin
        if (hosc_edge) begin
          warm_cnt_nxt = warm_cnt_r + 12'h001;
          if (warm_cnt_r == WAKE_LAST) begin
            state_nxt = DCMC_ST_RUN;
            osc_mode_nxt[BIT_CPU_MODE_HI:BIT_CPU_MODE_LO] = DCMC_CPUM_NORMAL;
            irq_stat_nxt[IRQ_OSC_READY] = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state_r    <= DCMC_ST_RUN;
      osc_mode_r <= OSC_MODE_RST;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      tmr_en_r   <= 2'h0;
      warm_cnt_r <= 12'h000;
      hi_div_r   <= 8'h00;
      lo_div_r   <= 2'h0;
      ack_r      <= 1'b0;
      rdat_r     <= 32'h0000_0000;
    end else begin
      state_r    <= state_nxt;
      osc_mode_r <= osc_mode_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      tmr_en_r   <= tmr_en_nxt;
      warm_cnt_r <= warm_cnt_nxt;
      hi_div_r   <= hi_div_nxt;
      lo_div_r   <= lo_div_nxt;
      ack_r      <= ack_nxt;
      rdat_r     <= rdat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      HIGH_OSC_EN_OUT         <= 1'b1;
      LOW_RC_EN_OUT           <= 1'b1;
      CPU_RUN_OUT             <= 1'b1;
      CPU_TICK_OUT            <= 1'b0;
      WDT_TICK_OUT            <= 1'b0;
      TIMER0_RUN_OUT          <= 1'b0;
      TIMER_COUNTER0_RUN_OUT  <= 1'b0;
      OSC_OUTPUT_PIN_GPIO_OUT <= 1'b0;
      IRQ_OUT                 <= 1'b0;
    end else begin
      HIGH_OSC_EN_OUT         <= gate.high_osc_run;
      LOW_RC_EN_OUT           <= gate.low_rc_run;
      CPU_RUN_OUT             <= gate.cpu_run;
      CPU_TICK_OUT            <= sys_tick & gate.cpu_run;
      WDT_TICK_OUT            <= lrc_edge & gate.low_rc_run & WATCHDOG_EN;
      TIMER0_RUN_OUT          <= tmr_en_r[TMR_EN_T0] && state_r != DCMC_ST_SLEEP
                                 && state_r != DCMC_ST_WARM;
      TIMER_COUNTER0_RUN_OUT  <= tmr_en_r[TMR_EN_TC0] && state_r != DCMC_ST_SLEEP
                                 && state_r != DCMC_ST_WARM;
      OSC_OUTPUT_PIN_GPIO_OUT <= HIGH_CLK_TYPE == DCMC_HCLK_RC;
      IRQ_OUT                 <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = rdat_r;

endmodule // dcmc_ctrl

// ### dcmc_ctrl_properties.sv
`timescale 1ns/1ps
module dcmc_ctrl_properties
  import dcmc_pkg::*;
#(
  parameter dcmc_hclk_t HIGH_CLK_TYPE = DCMC_HCLK_4M,
  parameter bit         WATCHDOG_EN   = 1'b1
)(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  input wire logic HIGH_OSC_EN_OUT,
  input wire logic LOW_RC_EN_OUT,
  input wire logic CPU_RUN_OUT,
  input wire logic CPU_TICK_OUT,
  input wire logic TIMER0_RUN_OUT,
  input wire logic TIMER_COUNTER0_RUN_OUT,
  input wire logic OSC_OUTPUT_PIN_GPIO_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // low rc may also stop in green only with 32k type and no watchdog
  localparam bit LRC_SLEEP_ONLY = (HIGH_CLK_TYPE != DCMC_HCLK_32K) || WATCHDOG_EN;

  property p_ack_one; (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one cycle after request");
  property p_ack_drop; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  property p_run_lrc; CPU_RUN_OUT |-> LOW_RC_EN_OUT; endproperty
  a_run_lrc: assert property (p_run_lrc) else $error("cpu runs with low rc stopped");
  property p_tick_run; CPU_TICK_OUT |-> CPU_RUN_OUT || $past(CPU_RUN_OUT); endproperty
  a_tick_run: assert property (p_tick_run) else $error("tick while cpu halted");
  property p_tick_gap; CPU_TICK_OUT |=> !CPU_TICK_OUT [*7]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  property p_sleep_all;
    LRC_SLEEP_ONLY && !LOW_RC_EN_OUT |-> !HIGH_OSC_EN_OUT && !TIMER0_RUN_OUT && !TIMER_COUNTER0_RUN_OUT;
  endproperty
  a_sleep_all: assert property (p_sleep_all) else $error("sleep left a clock or timer on");
  property p_lrc_halt; !LOW_RC_EN_OUT |-> !CPU_RUN_OUT; endproperty
  a_lrc_halt: assert property (p_lrc_halt) else $error("low rc stopped while cpu runs");
  property p_warm; $rose(HIGH_OSC_EN_OUT) && !CPU_RUN_OUT |=> !CPU_RUN_OUT [*8]; endproperty
  a_warm: assert property (p_warm) else $error("cpu ran before warmup");
  property p_gpio; $past(!SYS_RST_IN) |-> OSC_OUTPUT_PIN_GPIO_OUT == (HIGH_CLK_TYPE == DCMC_HCLK_RC); endproperty
  a_gpio: assert property (p_gpio) else $error("second pin gpio wrong");
endmodule // dcmc_ctrl_properties

bind dcmc_ctrl dcmc_ctrl_properties #(.HIGH_CLK_TYPE(HIGH_CLK_TYPE), .WATCHDOG_EN(WATCHDOG_EN)) u_props (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_ACK_OUT(WB_ACK_OUT), .HIGH_OSC_EN_OUT(HIGH_OSC_EN_OUT), .LOW_RC_EN_OUT(LOW_RC_EN_OUT),
  .CPU_RUN_OUT(CPU_RUN_OUT), .CPU_TICK_OUT(CPU_TICK_OUT), .TIMER0_RUN_OUT(TIMER0_RUN_OUT),
  .TIMER_COUNTER0_RUN_OUT(TIMER_COUNTER0_RUN_OUT), .OSC_OUTPUT_PIN_GPIO_OUT(OSC_OUTPUT_PIN_GPIO_OUT));

// ### dcmc_osc_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// oscillator sources, frozen low while disabled
// ---------------------------------------------------------------
module dcmc_osc_model #(
  parameter int HOSC_HALF_NS = 50,
  parameter int LRC_HALF_NS  = 200
)(
  input  wire logic hosc_en_in,
  input  wire logic lrc_en_in,
  output logic      hosc_clk_out,
  output logic      lrc_clk_out
);
  initial begin
    hosc_clk_out = 1'b0;
    forever begin
      #(HOSC_HALF_NS);
      hosc_clk_out = hosc_en_in ? ~hosc_clk_out : 1'b0;
    end
  end
  initial begin
    lrc_clk_out = 1'b0;
    // odd offset keeps the low rc out of phase with the system clock
    #7;
    forever begin
      #(LRC_HALF_NS);
      lrc_clk_out = lrc_en_in ? ~lrc_clk_out : 1'b0;
    end
  end
endmodule // dcmc_osc_model

// ### dual_clock_mode_controller_bench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module dual_clock_mode_controller_bench;
  import dcmc_pkg::*;
  localparam int DIV_N = 4;
  logic clk, rst, wake, t0_ovf, ack, hosc_en, lrc_en, run, tick, t0_run, tc0_run, gpio, irq, hosc, lrc, wdt;
  logic [31:0] rdat, rd;
  dcmc_wb_req_t req;
  int fail_count = 0;
  int compares = 0;
  int gap;

  dcmc_ctrl #(.CPU_DIV_N(DIV_N), .NOISE_FILTER(1'b1), .HIGH_CLK_TYPE(DCMC_HCLK_4M), .WATCHDOG_EN(1'b1)) uut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(req.cyc), .WB_STB_IN(req.stb), .WB_WE_IN(req.we),
    .WB_ADR_IN(req.adr), .WB_SEL_IN(req.sel), .WB_DAT_IN(req.dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .HOSC_CLK_IN(hosc), .LRC_CLK_IN(lrc), .WAKE_PORT_IN(wake), .TIMER0_OVF_IN(t0_ovf),
    .HIGH_OSC_EN_OUT(hosc_en), .LOW_RC_EN_OUT(lrc_en), .CPU_RUN_OUT(run), .CPU_TICK_OUT(tick),
    .WDT_TICK_OUT(wdt), .TIMER0_RUN_OUT(t0_run), .TIMER_COUNTER0_RUN_OUT(tc0_run),
    .OSC_OUTPUT_PIN_GPIO_OUT(gpio), .IRQ_OUT(irq));
  dcmc_osc_model u_osc (.hosc_en_in(hosc_en), .lrc_en_in(lrc_en), .hosc_clk_out(hosc), .lrc_clk_out(lrc));

  // ---------------------------------------------------------------
  // clock, watchdog, verdict
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #1000000;
    fail_count++;
    conclude();
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus and timing helpers
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 50);
    `CHK("ack", 1'b1, ack)
    rd = rdat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask
  task automatic chkrd(input string nm, input logic [9:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // watchdog pulses seen within a number of edges
  task automatic count_wdt(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (wdt === 1'b1) n++;
    end
  endtask
  // edges from one cpu tick to the next
  task automatic tick_gap(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    n = 0;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 500);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    req = '0; wake = 1'b0; t0_ovf = 1'b0; rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("hosc_en", 1'b1, hosc_en)
    `CHK("lrc_en", 1'b1, lrc_en)
    `CHK("cpu_run", 1'b1, run)
    `CHK("gpio", 1'b0, gpio)
    chkrd("osc_mode", ADDR_OSC_MODE, 32'h0);
    tick_gap(gap); `CHK("normal_gap", DIV_N * 4, gap)
    count_wdt(64, gap);
    `CHK("wdt_normal", 4, gap)
    wb(1'b1, 10'h000, 32'hffffffff);
    chkrd("unmapped", 10'h000, 32'h0);
    wb(1'b1, ADDR_TIMER_EN, 32'h3);
    wb(1'b1, ADDR_IRQ_MASK, 32'h7);
    wb(1'b1, ADDR_OSC_MODE, 32'hffffffe7);
    chkrd("osc_mode", ADDR_OSC_MODE, 32'h6);
    wait_n(200);
    `CHK("hosc_stop", 1'b0, hosc_en)
    `CHK("lrc_slow", 1'b1, lrc_en)
    `CHK("tc0_run", 1'b1, tc0_run)
    tick_gap(gap); `CHK("slow_gap", 64, gap)
    wb(1'b1, ADDR_OSC_MODE, 32'h1e);
    wait_n(8); `CHK("rsvd_run", 1'b1, run)
    wb(1'b1, ADDR_OSC_MODE, 32'h14);
    wait_n(8);
    `CHK("green_run", 1'b0, run)
    `CHK("green_lrc", 1'b1, lrc_en)
    `CHK("green_hosc", 1'b1, hosc_en)
    `CHK("green_t0", 1'b1, t0_run)
    chkrd("clk_status", ADDR_CLK_STATUS, 32'h17);
    `CHK("irq", 1'b1, irq)
    wb(1'b1, ADDR_IRQ_MASK, 32'h0);
    wait_n(3); `CHK("irq_masked", 1'b0, irq)
    chkrd("status", ADDR_IRQ_STATUS, 32'h2);
    wb(1'b1, ADDR_IRQ_STATUS, 32'h2);
    chkrd("status_clr", ADDR_IRQ_STATUS, 32'h0);
    // an overflow with timer0 disabled must not wake green
    wb(1'b1, ADDR_TIMER_EN, 32'h2);
    t0_ovf <= 1'b1;
    wait_n(10); `CHK("t0_off_wake", 1'b0, run)
    t0_ovf <= 1'b0;
    wb(1'b1, ADDR_TIMER_EN, 32'h3);
    t0_ovf <= 1'b1;
    wait_n(10); `CHK("green_wake", 1'b1, run)
    t0_ovf <= 1'b0;
    chkrd("after_green", ADDR_OSC_MODE, 32'h4);
    wb(1'b1, ADDR_OSC_MODE, 32'h0c);
    wait_n(8);
    `CHK("sleep_hosc", 1'b0, hosc_en)
    `CHK("sleep_lrc", 1'b0, lrc_en)
    `CHK("sleep_t0", 1'b0, t0_run)
    count_wdt(64, gap);
    `CHK("wdt_sleep", 0, gap)
    t0_ovf <= 1'b1;
    wait_n(10); `CHK("sleep_t0_wake", 1'b0, run)
    wake <= 1'b1;
    wait_n(10); `CHK("warm_hosc", 1'b1, hosc_en)
    wait_n(7900); `CHK("warm_run", 1'b0, run)
    gap = 0;
    while (run !== 1'b1 && gap < 600) begin @(posedge clk); gap++; end
    `CHK("woke", 1'b1, run)
    chkrd("after_sleep", ADDR_OSC_MODE, 32'h0);
    chkrd("status_all", ADDR_IRQ_STATUS, 32'h7);
    conclude();
  end
endmodule // dual_clock_mode_controller_bench
